// ---- hw/acc_ctrl.v ----
// Conversion channel control with an Avalon-MM register slave.
//
// Our own choices: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "acc_consts.vh"

module acc_ctrl (
  input  wire        ref_clk,
  input  wire        reset,
  input  wire        clkEn,
  // Avalon-MM slave.
  input  wire [4:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata,
  output wire        avs_waitrequest,
  // Trigger pin and converter core.
  input  wire        hardware_trigger_input,
  input  wire        convDone,
  input  wire [9:0]  convResult,
  output reg         convStart,
  output reg         convAbort,
  output wire        convPowerOn,
  output reg  [4:0]  convChannel,
  output reg  [27:0] extInputSel,
  output reg         highRefSel,
  output reg         lowRefSel,
  output wire        doneIrq
);

  // ----------------------------------------------------------------------
  // States
  // ----------------------------------------------------------------------
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_ARM  = 3'b010;
  localparam [2:0] ST_CONV = 3'b100;

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  reg  [2:0]  state_q;
  reg  [2:0]  state_d;
  reg         ack_q;
  reg         doneFlag_q;
  reg         doneFlag_d;
  reg         irqEn_q;
  reg         cont_q;
  reg  [4:0]  chSel_q;
  reg         trigHw_q;
  reg         cmpEn_q;
  reg         cmpGt_q;
  reg  [9:0]  cmpVal_q;
  reg  [9:0]  result_q;
  reg         start_d;
  reg         abort_d;
  reg  [31:0] rdata_d;
  wire        busReq;
  wire        busDo;
  wire        wrSc1;
  wire        wrSc2;
  wire        wrCmpLo;
  wire        wrCmpHi;
  wire        rdResLo;
  wire        hwTrig;
  wire        cmpTrue;
  wire        doneQual;
  wire [4:0]  newCh;
  wire [2:0]  wordIdx;

  // ----------------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------------
  // True when the channel code switches the converter off.
  function chanOff;
    input [4:0] ch;
    begin
      chanOff = (ch == `ACC_CH_OFF);
    end
  endfunction

  // One-hot select of the external inputs; codes above the last input
  // select none of them.
  function [27:0] extDecode;
    input [4:0] ch;
    integer     i;
    begin
      extDecode = 28'h0000000;
      for (i = 0; i < `ACC_NUM_EXT; i = i + 1) begin
        if (ch == i[4:0]) begin
          extDecode[i] = 1'b1;
        end
      end
    end
  endfunction

  // ----------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------
  // Every access waits one cycle so that read data come from a flop.
  assign busReq          = avs_read | avs_write;
  assign avs_waitrequest = busReq & ~ack_q;
  assign busDo           = clkEn & busReq & ack_q;
  assign wordIdx         = avs_address[4:2];
  assign wrSc1   = busDo & avs_write & avs_byteenable[0] &
                   (wordIdx == `ACC_IDX_SC1);
  assign wrSc2   = busDo & avs_write & avs_byteenable[0] &
                   (wordIdx == `ACC_IDX_SC2);
  assign wrCmpLo = busDo & avs_write & avs_byteenable[0] &
                   (wordIdx == `ACC_IDX_CMP);
  assign wrCmpHi = busDo & avs_write & avs_byteenable[1] &
                   (wordIdx == `ACC_IDX_CMP);
  assign rdResLo = busDo & avs_read & (wordIdx == `ACC_IDX_RES_LO);
  assign newCh   = avs_writedata[`ACC_SC1_CH_HI:`ACC_SC1_CH_LO]; // RL9

  // The handshake flop is high for one cycle per request, freezing with clkEn.
  always @(posedge ref_clk) begin
    if (reset) begin
      ack_q <= 1'b0;
    end else if (clkEn) begin
      ack_q <= busReq & ~ack_q;
    end
  end

  // ----------------------------------------------------------------------
  // Trigger and compare
  // ----------------------------------------------------------------------
  acc_trig_sync u_trig (
    .ref_clk   (ref_clk),
    .reset     (reset),
    .clkEn     (clkEn),
    .pinIn     (hardware_trigger_input),
    .risePulse (hwTrig)
  );

  // Less-than by default, greater-or-equal when selected.
  assign cmpTrue  = cmpGt_q ? (convResult >= cmpVal_q) :
                              (convResult < cmpVal_q);
  assign doneQual = convDone & (state_q == ST_CONV) &
                    (~cmpEn_q | cmpTrue);                   // RL2 RL3 RL14

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  // A control write always wins over a completion in the same cycle.
  always @* begin
    state_d = state_q;
    start_d = 1'b0;
    abort_d = 1'b0;
    case (state_q)
      ST_IDLE: begin
        state_d = ST_IDLE;
      end
      ST_ARM: begin
        if (hwTrig) begin
          state_d = ST_CONV;                                // RL6 RL8
          start_d = 1'b1;
        end
      end
      ST_CONV: begin
        if (convDone) begin
          if (cont_q) begin
            start_d = 1'b1;                                 // RL7 RL8
          end else if (trigHw_q) begin
            state_d = ST_ARM;                               // RL6 RL13
          end else begin
            state_d = ST_IDLE;                              // RL6 RL13
          end
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    if (wrSc1) begin
      abort_d = (state_q == ST_CONV);                       // RL1
      start_d = 1'b0;
      if (chanOff(newCh)) begin
        state_d = ST_IDLE;                                  // RL11 RL12 RL17
      end else if (trigHw_q) begin
        // Hardware mode only arms here; the pin edge starts it later.
        state_d = ST_ARM;                                   // RL15
      end else begin
        state_d = ST_CONV;                                  // RL1 RL15
        start_d = 1'b1;
      end
    end
  end

  // State and converter strobes.
  always @(posedge ref_clk) begin
    if (reset) begin
      state_q   <= ST_IDLE;
      convStart <= 1'b0;
      convAbort <= 1'b0;
    end else if (clkEn) begin
      state_q   <= state_d;
      convStart <= start_d;
      convAbort <= abort_d;
    end
  end

  // Power follows the converting state, so single mode drops to low
  // power by itself after each result.
  assign convPowerOn = state_q[2];                          // RL11 RL13

  // ----------------------------------------------------------------------
  // Done flag
  // ----------------------------------------------------------------------
  // Setting beats clearing, so a result landing on a clear is kept.
  always @* begin
    doneFlag_d = doneFlag_q;
    if (wrSc1 | rdResLo) begin
      doneFlag_d = 1'b0;                                    // RL4
    end
    if (doneQual) begin
      doneFlag_d = 1'b1;                                    // RL2 RL3
    end
  end

  // The request is a level that follows flag and enable together.
  assign doneIrq = doneFlag_q & irqEn_q;                    // RL5

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  // The flag bit is read only; software writes to it are dropped.
  always @(posedge ref_clk) begin
    if (reset) begin
      doneFlag_q <= 1'b0;
      irqEn_q    <= 1'b0;
      cont_q     <= 1'b0;
      chSel_q    <= `ACC_RST_CH;
      trigHw_q   <= 1'b0;
      cmpEn_q    <= 1'b0;
      cmpGt_q    <= 1'b0;
      cmpVal_q   <= 10'h000;
      result_q   <= 10'h000;
    end else if (clkEn) begin
      doneFlag_q <= doneFlag_d;
      if (wrSc1) begin
        irqEn_q <= avs_writedata[`ACC_SC1_IEN];
        cont_q  <= avs_writedata[`ACC_SC1_CONT];
        chSel_q <= newCh;                                   // RL9
      end
      if (wrSc2) begin
        trigHw_q <= avs_writedata[`ACC_SC2_TRIG];           // RL15
        cmpEn_q  <= avs_writedata[`ACC_SC2_CMPEN];          // RL14
        cmpGt_q  <= avs_writedata[`ACC_SC2_CMPGT];
      end
      if (wrCmpLo) begin
        cmpVal_q[7:0] <= avs_writedata[7:0];
      end
      if (wrCmpHi) begin
        cmpVal_q[9:8] <= avs_writedata[9:8];
      end
      if (doneQual) begin
        result_q <= convResult;                             // RL14
      end
    end
  end

  // ----------------------------------------------------------------------
  // Channel select outputs
  // ----------------------------------------------------------------------
  // The reserved code and the off code drive no select at all, which
  // isolates the converter input from every source.
  always @(posedge ref_clk) begin
    if (reset) begin
      convChannel <= `ACC_RST_CH;
      extInputSel <= 28'h0000000;
      highRefSel  <= 1'b0;
      lowRefSel   <= 1'b0;
    end else if (clkEn) begin
      convChannel <= chSel_q;
      extInputSel <= chanOff(chSel_q) ? 28'h0000000 :
                     extDecode(chSel_q);                    // RL10 RL11
      highRefSel  <= (chSel_q == `ACC_CH_HIGH_REF);         // RL10
      lowRefSel   <= (chSel_q == `ACC_CH_LOW_REF);          // RL10
    end
  end

  // ----------------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------------
  // Captured in the waiting cycle and held through the answering edge;
  // unmapped words read as zero.
  always @* begin
    rdata_d = 32'h00000000;
    case (wordIdx)
      `ACC_IDX_SC1: begin
        rdata_d[`ACC_SC1_DONE] = doneFlag_q;
        rdata_d[`ACC_SC1_IEN]  = irqEn_q;
        rdata_d[`ACC_SC1_CONT] = cont_q;
        rdata_d[`ACC_SC1_CH_HI:`ACC_SC1_CH_LO] = chSel_q;
      end
      `ACC_IDX_SC2: begin
        rdata_d[`ACC_SC2_ACTIVE] = state_q[2];              // RL16
        rdata_d[`ACC_SC2_TRIG]   = trigHw_q;
        rdata_d[`ACC_SC2_CMPEN]  = cmpEn_q;
        rdata_d[`ACC_SC2_CMPGT]  = cmpGt_q;
      end
      `ACC_IDX_RES_LO: begin
        rdata_d[7:0] = result_q[7:0];
      end
      `ACC_IDX_RES_HI: begin
        rdata_d[1:0] = result_q[9:8];
      end
      `ACC_IDX_CMP: begin
        rdata_d[9:0] = cmpVal_q;
      end
      default: begin
        rdata_d = 32'h00000000;
      end
    endcase
  end

  // Read data register.
  always @(posedge ref_clk) begin
    if (reset) begin
      avs_readdata <= 32'h00000000;
    end else if (clkEn & avs_read & ~ack_q) begin
      avs_readdata <= rdata_d;
    end
  end

endmodule
`default_nettype wire

// ---- pkg/acc_consts.vh ----
// Register map, field positions and reset values of the conversion control.
//
// Overview of operation
// [RL1] Control write aborts, restarts unless channel off
// [RL2] Done flag set per conversion, read only
// [RL3] With compare on, done only if true
// [RL4] Control write or low result read clears done
// [RL5] Done with interrupt enable raises request
// [RL6] Single mode: one conversion per trigger
// [RL7] Continuous software mode repeats back to back
// [RL8] Continuous hardware mode starts on trigger
// [RL9] Channel select is bits four to zero
// [RL10] Codes: inputs 0-27, reserved, high, low reference
// [RL11] All-ones channel powers converter off, isolated
// [RL12] All-ones write stops continuous, no extra conversion
// [RL13] Single mode returns to low power after conversion
// [RL14] Compare enable bit gates completion and result
// [RL15] Trigger select picks software or hardware start
// [RL16] Active bit set at start, cleared at end
// [RL17] All-ones write aborts and leaves converter idle
// [RL18] Software must not write reserved code 11100
`ifndef ACC_CONSTS_VH
`define ACC_CONSTS_VH

// ----------------------------------------------------------------------
// Register word indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define ACC_IDX_SC1      3'h0
`define ACC_IDX_SC2      3'h1
`define ACC_IDX_RES_LO   3'h2
`define ACC_IDX_RES_HI   3'h3
`define ACC_IDX_CMP      3'h4

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define ACC_SC1_DONE     7
`define ACC_SC1_IEN      6
`define ACC_SC1_CONT     5
`define ACC_SC1_CH_HI    4
`define ACC_SC1_CH_LO    0
`define ACC_SC2_ACTIVE   7
`define ACC_SC2_TRIG     6
`define ACC_SC2_CMPEN    5
`define ACC_SC2_CMPGT    4

// ----------------------------------------------------------------------
// Channel codes and reset values
// ----------------------------------------------------------------------
`define ACC_CH_LAST_EXT  5'h1b
`define ACC_CH_RESERVED  5'h1c
`define ACC_CH_HIGH_REF  5'h1d
`define ACC_CH_LOW_REF   5'h1e
`define ACC_CH_OFF       5'h1f
`define ACC_RST_CH       5'h1f
`define ACC_NUM_EXT      28

`endif

// ---- hw/acc_trig_sync.v ----
// Two-stage synchroniser and rising-edge detector for the trigger pin.
`timescale 1ns/1ps
`default_nettype none

module acc_trig_sync (
  input  wire ref_clk,
  input  wire reset,
  input  wire clkEn,
  input  wire pinIn,
  output wire risePulse
);

  reg meta_q;
  reg sync_q;
  reg prev_q;

  // ----------------------------------------------------------------------
  // Synchroniser chain
  // ----------------------------------------------------------------------
  // Only the second stage and its delayed copy feed the edge detector.
  always @(posedge ref_clk) begin
    if (reset) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end else if (clkEn) begin
      meta_q <= pinIn;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  // A pulse of one cycle marks each rising edge of the pin.
  assign risePulse = clkEn & sync_q & ~prev_q;

endmodule
`default_nettype wire

// ---- tb/acc_ctrl_asserts.sv ----
// Concurrent checks on the ports of the conversion control.
`timescale 1ns/1ps
`default_nettype none

module acc_ctrl_asserts (
  input wire        ref_clk,
  input wire        reset,
  input wire        clkEn,
  input wire [4:0]  avs_address,
  input wire        avs_read,
  input wire        avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0]  avs_byteenable,
  input wire        avs_waitrequest,
  input wire        convDone,
  input wire        convStart,
  input wire        convAbort,
  input wire        convPowerOn,
  input wire [4:0]  convChannel,
  input wire [27:0] extInputSel,
  input wire        highRefSel,
  input wire        lowRefSel,
  input wire        doneIrq
);
  // --------------------------------------------------------------
  // Accepted accesses and shadow copies of the mode bits
  // --------------------------------------------------------------
  logic contMode_q;
  logic hwTrig_q;
  wire  busWr = clkEn && avs_write && !avs_waitrequest && avs_byteenable[0];
  wire  sc1Wr = busWr && avs_address[4:2] == 3'h0;
  wire  rdLow = avs_read && !avs_waitrequest && avs_address[4:2] == 3'h2;
  wire  chOff = avs_writedata[4:0] == 5'h1f;

  // Mode shadows let the checks know which kind of start to expect.
  always @(posedge ref_clk) begin
    if (reset) begin
      contMode_q <= 1'b0;
      hwTrig_q   <= 1'b0;
    end else begin
      if (sc1Wr) begin
        contMode_q <= avs_writedata[5];
      end
      if (busWr && avs_address[4:2] == 3'h1) begin
        hwTrig_q <= avs_writedata[6];
      end
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  a_write_start: assert property (
    sc1Wr && !chOff && !hwTrig_q |=> convStart)
    else $error("no start after control write");
  a_hw_wait: assert property (
    sc1Wr && hwTrig_q |=> !convStart)
    else $error("start without trigger in hardware mode");
  a_write_abort: assert property (
    sc1Wr && convPowerOn |=> convAbort)
    else $error("running conversion not aborted");
  a_off_idle: assert property (
    sc1Wr && chOff |=> (!convStart && !convPowerOn)[*2])
    else $error("converter not idle after off code");
  a_cont_next: assert property (
    convDone && convPowerOn && contMode_q && !sc1Wr
    |=> convStart && convPowerOn)
    else $error("continuous conversion did not restart");
  a_single_stop: assert property (
    convDone && convPowerOn && !contMode_q && !sc1Wr
    |=> !convPowerOn && !convStart)
    else $error("single conversion did not stop");
  a_irq_cause: assert property (
    $rose(doneIrq) |-> $past(convDone))
    else $error("request rose without a completion");
  a_done_clear: assert property (
    (sc1Wr || rdLow) && !convDone |=> !doneIrq)
    else $error("request not cleared");
  // The channel output is a second register stage behind the field.
  a_chan_copy: assert property (
    sc1Wr |-> ##2 convChannel == $past(avs_writedata[4:0], 2))
    else $error("channel field not taken");
  a_ext_decode: assert property (
    convChannel <= 5'h1b |-> extInputSel == 28'h1 << convChannel)
    else $error("external input select wrong");
  a_ref_decode: assert property (
    (highRefSel == (convChannel == 5'h1d)) &&
    (lowRefSel == (convChannel == 5'h1e)))
    else $error("reference select wrong");
endmodule

`default_nettype wire

// ---- tb/acc_ctrl_tb_top.sv ----
// Self-checking bench for the conversion channel control.
`timescale 1ns/1ps
`default_nettype none

module acc_ctrl_tb_top;
  // --------------------------------------------------------------
  // Stimulus, design and bus tasks
  // --------------------------------------------------------------
  logic        ref_clk = 1'b0;
  logic        reset = 1'b1;
  logic [4:0]  avs_address = 5'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic        hardware_trigger_input = 1'b0;
  logic        convDone = 1'b0;
  logic [9:0]  convResult = 10'h000;
  logic [31:0] avs_readdata;
  logic [31:0] rdData;
  logic        avs_waitrequest, convStart, convAbort, convPowerOn;
  logic        highRefSel, lowRefSel, doneIrq, stS, abS;
  logic [4:0]  convChannel;
  logic [27:0] extInputSel;
  int          numErrors = 0;
  int          checksDone = 0;

  always #5 ref_clk = ~ref_clk;

  acc_ctrl u_acc_ctrl (.ref_clk, .reset, .clkEn(1'b1), .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable(4'hf), .avs_readdata,
    .avs_waitrequest, .hardware_trigger_input, .convDone, .convResult,
    .convStart, .convAbort, .convPowerOn, .convChannel, .extInputSel,
    .highRefSel, .lowRefSel, .doneIrq);

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checksDone, numErrors);
    if (numErrors == 0 && checksDone > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checksDone++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      numErrors++;
    end
  endtask

  // One access; the request stays up until waitrequest is seen low.
  task automatic bus(input logic wr, input logic [2:0] idx, input logic [7:0] d);
    logic w;
    w = 1'b1;
    avs_address <= {idx, 2'b00};
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= {24'h0, d};
    for (int n = 0; n < 20 && w !== 1'b0; n++) begin
      @(posedge ref_clk);
      w = avs_waitrequest;
      rdData = avs_readdata;
    end
    if (w !== 1'b0) begin
      numErrors++;
      report_and_stop;
    end
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    // Start and abort stand for the one cycle after the accepting edge.
    @(posedge ref_clk);
    stS = convStart;
    abS = convAbort;
  endtask

  // Completion pulse from the converter core with its result.
  task automatic conv(input logic [9:0] r);
    convResult <= r;
    convDone <= 1'b1;
    @(posedge ref_clk);
    convDone <= 1'b0;
    @(posedge ref_clk);
    stS = convStart;
  endtask

  // Raise the pin and wait, bounded, for the start it causes.
  task automatic trig;
    bit seen;
    seen = 1'b0;
    hardware_trigger_input <= 1'b1;
    for (int n = 0; n < 10 && !seen; n++) begin
      @(posedge ref_clk);
      seen = (convStart === 1'b1);
    end
    hardware_trigger_input <= 1'b0;
    stS = seen;
    if (!seen) begin
      numErrors++;
      report_and_stop;
    end
  endtask

  initial begin
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    bus(1'b0, 3'h0, 8'h00);
    chk(rdData, 32'h1f);
    bus(1'b0, 3'h5, 8'h00);
    chk(rdData, 32'h0);
    $display("test reset done");
    bus(1'b1, 3'h0, 8'hc3);
    chk(32'(stS), 32'h1);
    bus(1'b0, 3'h1, 8'h00);
    chk(rdData, 32'h80);
    conv(10'h2a5);
    chk(32'({stS, convPowerOn, doneIrq}), 32'h1);
    bus(1'b0, 3'h0, 8'h00);
    chk(rdData, 32'hc3);
    bus(1'b0, 3'h2, 8'h00);
    chk(rdData, 32'ha5);
    chk(32'(doneIrq), 32'h0);
    bus(1'b0, 3'h3, 8'h00);
    chk(rdData, 32'h2);
    bus(1'b0, 3'h1, 8'h00);
    chk(rdData, 32'h0);
    $display("test single done");
    bus(1'b1, 3'h0, 8'h05);
    bus(1'b1, 3'h0, 8'h06);
    chk(32'({abS, stS}), 32'h3);
    bus(1'b1, 3'h0, 8'h1f);
    chk(32'({abS, stS, convPowerOn}), 32'h4);
    bus(1'b1, 3'h0, 8'h25);
    conv(10'h011);
    chk(32'({stS, convPowerOn}), 32'h3);
    bus(1'b1, 3'h0, 8'h3f);
    chk(32'({abS, stS, convPowerOn}), 32'h4);
    $display("test continuous done");
    bus(1'b1, 3'h1, 8'h20);
    bus(1'b1, 3'h4, 8'h80);
    bus(1'b1, 3'h0, 8'h01);
    conv(10'h090);
    bus(1'b0, 3'h0, 8'h00);
    chk(rdData, 32'h01);
    bus(1'b1, 3'h0, 8'h01);
    conv(10'h010);
    bus(1'b0, 3'h0, 8'h00);
    chk(rdData, 32'h81);
    bus(1'b0, 3'h2, 8'h00);
    chk(rdData, 32'h10);
    // Greater-or-equal mode: below the level fails, equal passes.
    bus(1'b1, 3'h1, 8'h30);
    bus(1'b1, 3'h0, 8'h01);
    conv(10'h07f);
    bus(1'b0, 3'h0, 8'h00);
    chk(rdData, 32'h01);
    bus(1'b1, 3'h0, 8'h01);
    conv(10'h080);
    bus(1'b0, 3'h0, 8'h00);
    chk(rdData, 32'h81);
    $display("test compare done");
    bus(1'b1, 3'h1, 8'h40);
    bus(1'b1, 3'h0, 8'h24);
    chk(32'(stS), 32'h0);
    trig;
    chk(32'(stS), 32'h1);
    conv(10'h000);
    chk(32'(stS), 32'h1);
    bus(1'b1, 3'h0, 8'h04);
    trig;
    chk(32'(stS), 32'h1);
    conv(10'h000);
    chk(32'({stS, convPowerOn}), 32'h0);
    bus(1'b1, 3'h1, 8'h00);
    $display("test hardware done");
    for (int c = 0; c < 31; c++) begin
      if (c == 28) continue;
      bus(1'b1, 3'h0, 8'(c));
      // The selects follow the stored field one edge later.
      @(posedge ref_clk);
      chk(32'(convChannel), c);
      chk(32'(extInputSel), c < 28 ? 32'h1 << c : 32'h0);
      chk(32'({highRefSel, lowRefSel}), c == 29 ? 2 : c == 30 ? 1 : 0);
    end
    bus(1'b1, 3'h0, 8'h1f);
    $display("test decode done");
    report_and_stop;
  end
endmodule

bind acc_ctrl acc_ctrl_asserts u_acc_ctrl_asserts (.ref_clk, .reset, .clkEn,
  .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
  .avs_waitrequest, .convDone, .convStart, .convAbort, .convPowerOn,
  .convChannel, .extInputSel, .highRefSel, .lowRefSel, .doneIrq);

`default_nettype wire
